// ==== pkg/ffo_consts.svh ====
`ifndef FFO_CONSTS_SVH
`define FFO_CONSTS_SVH

// Lane and register widths
`define FFO_DATA_W 18
`define FFO_THR_W 17
`define FFO_BYTE_W 8
`define FFO_PTR_W 3
`define FFO_DEPTH_SEL_W 2
`define FFO_BITS_W 5
`define FFO_COUNT_W 18

// Significant threshold bits for the shallowest variant
`define FFO_BITS_NINE_NINE 5'h0e
`define FFO_BITS_OTHER 5'h0d
// Above this many bits a 9-bit bus needs a third cycle per register
`define FFO_BITS_TWO_BYTES 5'h10

// Cycles per register in the parallel sequence
`define FFO_STEPS_X18 3'h1
`define FFO_STEPS_X9 3'h2
`define FFO_STEPS_X9_DEEP 3'h3

// Lane positions
`define FFO_LO_LSB 0
`define FFO_HI_LSB 8
`define FFO_TOP_BIT 16
`define FFO_PAR_HI_LSB 9

// Width select encoding
`define FFO_WIDTH_X9 1'b0
`define FFO_WIDTH_X18 1'b1

// Reset values
`define FFO_EMPTY_THR_RST 17'h0_0000
`define FFO_FULL_THR_RST 17'h0_0000
`define FFO_DATA_RST 18'h0_0000

`endif

// ==== pkg/ffo_pkg.sv ====
package ffo_pkg;

  // Part of a threshold carried in one cycle
  typedef enum logic [1:0] {
    FFO_PART_LOW  = 2'h0,
    FFO_PART_HIGH = 2'h1,
    FFO_PART_TOP  = 2'h3,
    FFO_PART_WIDE = 2'h2
  } ffo_part_t;

  typedef enum logic {
    FFO_LOAD_PARALLEL = 1'b0,
    FFO_LOAD_SERIAL   = 1'b1
  } ffo_load_t;

  typedef struct packed {
    logic      full_reg;
    ffo_part_t part;
  } ffo_slot_t;

endpackage

// ==== logic/ffo_seq_ptr.sv ====
`timescale 1ns/1ps
`include "ffo_consts.svh"

module ffo_seq_ptr #(
  parameter int PTR_W = `FFO_PTR_W
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             clear,
  input  wire logic             step,
  input  wire logic [PTR_W-1:0] last,
  output logic      [PTR_W-1:0] ptr_q,
  output logic                  wrap_q
);

  logic [PTR_W-1:0] ptr_d;
  logic             wrap_d;

  always_comb begin
    ptr_d  = ptr_q;
    wrap_d = 1'b0;
    if (clear) begin
      ptr_d = '0;
    end else if (step) begin
      // Compare with >= so a shortened sequence still wraps
      if (ptr_q >= last) begin
        ptr_d  = '0;
        wrap_d = 1'b1;
      end else begin
        ptr_d = PTR_W'(ptr_q + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ptr_q  <= '0;
      wrap_q <= 1'b0;
    end else begin
      ptr_q  <= ptr_d;
      wrap_q <= wrap_d;
    end
  end

endmodule

// ==== logic/ffo_occupancy.sv ====
`timescale 1ns/1ps
`include "ffo_consts.svh"

module ffo_occupancy #(
  parameter int COUNT_W = `FFO_COUNT_W
) (
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic               clear,
  input  wire logic               fall_through_timing,
  input  wire logic [COUNT_W-1:0] mem_count,
  input  wire logic               out_reg_valid,
  output logic      [COUNT_W-1:0] flag_count_q
);

  logic [COUNT_W-1:0] flag_count_d;

  always_comb begin
    flag_count_d = '0;
    if (!clear) begin
      if (fall_through_timing && out_reg_valid) begin
        flag_count_d = COUNT_W'(mem_count + 1'b1);
      end else begin
        flag_count_d = mem_count;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flag_count_q <= '0;
    end else begin
      flag_count_q <= flag_count_d;
    end
  end

endmodule

// ==== logic/ffo_flag_offset.sv ====
`timescale 1ns/1ps
`include "ffo_consts.svh"

// Behaviour
// - On a 9-bit bus cycles one and two carry empty threshold bits 1-8 and 9-16 on lanes 0-7, lane 8 ignored.
// - On the deepest variant with both buses 9-bit a third cycle carries empty bit 17 on lane 0, and full uses cycles four to six alike.
// - On shallower variants with a 9-bit bus the full threshold follows in cycles three and four, low byte first.
// - On an 18-bit bus empty goes in cycle one and full in cycle two, on lanes 0-15, or lanes 0-7 and 9-16 with interspersed parity.
// - Deepest variant with 9-bit input and 18-bit output programs in exactly four write cycles.
// - Deepest variant with 9-bit output and 18-bit input reads back in exactly four read cycles.
// - Deepest variant with both widths 9-bit takes six cycles to program or read back.
// - Each threshold keeps 14 to 17 bits by depth in 9-to-9 mode and one bit fewer in other modes.
// - Lane bits beyond the significant threshold bits are ignored on a write.
// - In fall-through timing the flag occupancy count includes the output register word.
// - Load select low during master clear enables parallel loading, high selects serial.
// - Parallel readback is allowed in either loading method and no serial readback exists.
module ffo_flag_offset #(
  parameter int COUNT_W = `FFO_COUNT_W
) (
  input  wire logic                            clk_sys,
  input  wire logic                            nrst,
  input  wire logic                            master_clear_n,
  input  wire logic                            load_select_n,
  input  wire logic                            write_en_n,
  input  wire logic                            read_en_n,
  input  wire logic                            input_width_sel,
  input  wire logic                            output_width_sel,
  input  wire logic                            interspersed_parity,
  input  wire logic [`FFO_DEPTH_SEL_W-1:0]     depth_sel,
  input  wire logic                            fall_through_timing,
  input  wire logic [`FFO_DATA_W-1:0]          data_in,
  input  wire logic [COUNT_W-1:0]              mem_count,
  input  wire logic                            out_reg_valid,
  output logic      [`FFO_DATA_W-1:0]          data_out,
  output logic                                 data_out_valid,
  output logic      [`FFO_THR_W-1:0]           empty_threshold,
  output logic      [`FFO_THR_W-1:0]           full_threshold,
  output logic                                 parallel_load_en,
  output logic      [`FFO_PTR_W-1:0]           write_step,
  output logic      [`FFO_PTR_W-1:0]           read_step,
  output logic                                 write_seq_done,
  output logic                                 read_seq_done,
  output logic                                 write_refused,
  output logic      [COUNT_W-1:0]              flag_count
);

  // Significant bits for the current mode and depth
  function automatic logic [`FFO_BITS_W-1:0] sig_bits(
    input logic                        nine_nine,
    input logic [`FFO_DEPTH_SEL_W-1:0] depth
  );
    logic [`FFO_BITS_W-1:0] base;
    base = nine_nine ? `FFO_BITS_NINE_NINE : `FFO_BITS_OTHER;
    sig_bits = `FFO_BITS_W'(base + depth);
  endfunction

  function automatic logic [`FFO_THR_W-1:0] bit_mask(
    input logic [`FFO_BITS_W-1:0] bits
  );
    logic [`FFO_THR_W-1:0] m;
    m = '0;
    for (int i = 0; i < `FFO_THR_W; i++) begin
      m[i] = (i < int'(bits));
    end
    bit_mask = m;
  endfunction

  // Cycles one register takes on a bus of the given width
  function automatic logic [`FFO_PTR_W-1:0] steps_per_reg(
    input logic                   bus9,
    input logic [`FFO_BITS_W-1:0] bits
  );
    if (!bus9) begin
      steps_per_reg = `FFO_STEPS_X18;
    end else if (bits > `FFO_BITS_TWO_BYTES) begin
      steps_per_reg = `FFO_STEPS_X9_DEEP;
    end else begin
      steps_per_reg = `FFO_STEPS_X9;
    end
  endfunction

  function automatic ffo_pkg::ffo_slot_t slot_of(
    input logic                  bus9,
    input logic [`FFO_PTR_W-1:0] steps,
    input logic [`FFO_PTR_W-1:0] ptr
  );
    ffo_pkg::ffo_slot_t    s;
    logic [`FFO_PTR_W-1:0] idx;
    s.full_reg = (ptr >= steps);
    idx = s.full_reg ? `FFO_PTR_W'(ptr - steps) : ptr;
    if (!bus9) begin
      s.part = ffo_pkg::FFO_PART_WIDE;
    end else if (idx == 3'h0) begin
      s.part = ffo_pkg::FFO_PART_LOW;
    end else if (idx == 3'h1) begin
      s.part = ffo_pkg::FFO_PART_HIGH;
    end else begin
      s.part = ffo_pkg::FFO_PART_TOP;
    end
    slot_of = s;
  endfunction

  // Insert one cycle's lanes into a threshold
  function automatic logic [`FFO_THR_W-1:0] merge_lanes(
    input logic [`FFO_THR_W-1:0] old,
    input ffo_pkg::ffo_part_t    part,
    input logic [`FFO_DATA_W-1:0] d,
    input logic                  par,
    input logic [`FFO_THR_W-1:0] mask
  );
    logic [`FFO_THR_W-1:0] v;
    v = old;
    unique case (part)
      ffo_pkg::FFO_PART_LOW: begin
        v[`FFO_LO_LSB +: `FFO_BYTE_W] = d[`FFO_LO_LSB +: `FFO_BYTE_W];
      end
      ffo_pkg::FFO_PART_HIGH: begin
        v[`FFO_HI_LSB +: `FFO_BYTE_W] = d[`FFO_LO_LSB +: `FFO_BYTE_W];
      end
      ffo_pkg::FFO_PART_TOP: begin
        v[`FFO_TOP_BIT] = d[`FFO_LO_LSB];
      end
      ffo_pkg::FFO_PART_WIDE: begin
        v[`FFO_LO_LSB +: `FFO_BYTE_W] = d[`FFO_LO_LSB +: `FFO_BYTE_W];
        if (par) begin
          v[`FFO_HI_LSB +: `FFO_BYTE_W] = d[`FFO_PAR_HI_LSB +: `FFO_BYTE_W];
        end else begin
          v[`FFO_HI_LSB +: `FFO_BYTE_W] = d[`FFO_HI_LSB +: `FFO_BYTE_W];
        end
      end
    endcase
    // Bits beyond the depth are dropped
    merge_lanes = v & mask;
  endfunction

  // Place one cycle's part of a threshold on the output lanes
  function automatic logic [`FFO_DATA_W-1:0] lanes_of(
    input logic [`FFO_THR_W-1:0] val,
    input ffo_pkg::ffo_part_t    part,
    input logic                  par
  );
    logic [`FFO_DATA_W-1:0] q;
    q = '0;
    unique case (part)
      ffo_pkg::FFO_PART_LOW: begin
        q[`FFO_LO_LSB +: `FFO_BYTE_W] = val[`FFO_LO_LSB +: `FFO_BYTE_W];
      end
      ffo_pkg::FFO_PART_HIGH: begin
        q[`FFO_LO_LSB +: `FFO_BYTE_W] = val[`FFO_HI_LSB +: `FFO_BYTE_W];
      end
      ffo_pkg::FFO_PART_TOP: begin
        q[`FFO_LO_LSB] = val[`FFO_TOP_BIT];
      end
      ffo_pkg::FFO_PART_WIDE: begin
        q[`FFO_LO_LSB +: `FFO_BYTE_W] = val[`FFO_LO_LSB +: `FFO_BYTE_W];
        if (par) begin
          q[`FFO_PAR_HI_LSB +: `FFO_BYTE_W] = val[`FFO_HI_LSB +: `FFO_BYTE_W];
        end else begin
          q[`FFO_HI_LSB +: `FFO_BYTE_W] = val[`FFO_HI_LSB +: `FFO_BYTE_W];
        end
      end
    endcase
    lanes_of = q;
  endfunction

  logic                   clear;
  logic                   nine_nine;
  logic                   bus9_w;
  logic                   bus9_r;
  logic [`FFO_BITS_W-1:0] bits;
  logic [`FFO_THR_W-1:0]  mask;
  logic [`FFO_PTR_W-1:0]  steps_w;
  logic [`FFO_PTR_W-1:0]  steps_r;
  logic [`FFO_PTR_W-1:0]  last_w;
  logic [`FFO_PTR_W-1:0]  last_r;
  ffo_pkg::ffo_slot_t     slot_w;
  ffo_pkg::ffo_slot_t     slot_r;
  logic                   wr_req;
  logic                   rd_req;
  logic                   wr_take;
  logic [`FFO_PTR_W-1:0]  write_ptr;
  logic [`FFO_PTR_W-1:0]  read_ptr;
  logic                   write_wrap;
  logic                   read_wrap;
  logic [`FFO_THR_W-1:0]  rd_val;

  ffo_pkg::ffo_load_t     load_mode_q;
  ffo_pkg::ffo_load_t     load_mode_d;
  logic [`FFO_THR_W-1:0]  empty_thr_q;
  logic [`FFO_THR_W-1:0]  empty_thr_d;
  logic [`FFO_THR_W-1:0]  full_thr_q;
  logic [`FFO_THR_W-1:0]  full_thr_d;
  logic                   refused_q;
  logic                   refused_d;
  logic [`FFO_DATA_W-1:0] data_out_q;
  logic [`FFO_DATA_W-1:0] data_out_d;
  logic                   out_valid_q;
  logic                   out_valid_d;

  assign clear     = !master_clear_n;
  assign nine_nine = (input_width_sel == `FFO_WIDTH_X9)
                   && (output_width_sel == `FFO_WIDTH_X9);
  assign bus9_w    = (input_width_sel == `FFO_WIDTH_X9);
  assign bus9_r    = (output_width_sel == `FFO_WIDTH_X9);

  assign bits = sig_bits(nine_nine, depth_sel);
  assign mask = bit_mask(bits);

  assign steps_w = steps_per_reg(bus9_w, bits);
  assign steps_r = steps_per_reg(bus9_r, bits);
  assign last_w  = `FFO_PTR_W'({steps_w[1:0], 1'b0} - 3'h1);
  assign last_r  = `FFO_PTR_W'({steps_r[1:0], 1'b0} - 3'h1);

  assign slot_w = slot_of(bus9_w, steps_w, write_ptr);
  assign slot_r = slot_of(bus9_r, steps_r, read_ptr);

  assign wr_req = !clear && !load_select_n && !write_en_n;
  assign rd_req = !clear && !load_select_n && !read_en_n;

  assign wr_take = wr_req && (load_mode_q == ffo_pkg::FFO_LOAD_PARALLEL);

  ffo_seq_ptr #(
    .PTR_W (`FFO_PTR_W)
  ) u_write_ptr (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clear   (clear),
    .step    (wr_take),
    .last    (last_w),
    .ptr_q   (write_ptr),
    .wrap_q  (write_wrap)
  );

  ffo_seq_ptr #(
    .PTR_W (`FFO_PTR_W)
  ) u_read_ptr (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clear   (clear),
    .step    (rd_req),
    .last    (last_r),
    .ptr_q   (read_ptr),
    .wrap_q  (read_wrap)
  );

  ffo_occupancy #(
    .COUNT_W (COUNT_W)
  ) u_occupancy (
    .clk_sys             (clk_sys),
    .nrst                (nrst),
    .clear               (clear),
    .fall_through_timing (fall_through_timing),
    .mem_count           (mem_count),
    .out_reg_valid       (out_reg_valid),
    .flag_count_q        (flag_count)
  );

  // Load method
  always_comb begin
    load_mode_d = load_mode_q;
    if (clear) begin
      load_mode_d = load_select_n ? ffo_pkg::FFO_LOAD_SERIAL
                                  : ffo_pkg::FFO_LOAD_PARALLEL;
    end
  end

  // Threshold registers
  always_comb begin
    empty_thr_d = empty_thr_q;
    full_thr_d  = full_thr_q;
    refused_d   = wr_req && !wr_take;
    if (clear) begin
      empty_thr_d = `FFO_EMPTY_THR_RST;
      full_thr_d  = `FFO_FULL_THR_RST;
    end else if (wr_take) begin
      if (slot_w.full_reg) begin
        full_thr_d = merge_lanes(full_thr_q, slot_w.part, data_in,
                                 interspersed_parity, mask);
      end else begin
        empty_thr_d = merge_lanes(empty_thr_q, slot_w.part, data_in,
                                  interspersed_parity, mask);
      end
    end
  end

  // Readback, held until the next read or master clear
  always_comb begin
    rd_val      = (slot_r.full_reg ? full_thr_q : empty_thr_q) & mask;
    data_out_d  = data_out_q;
    out_valid_d = 1'b0;
    if (clear) begin
      data_out_d = `FFO_DATA_RST;
    end else if (rd_req) begin
      data_out_d  = lanes_of(rd_val, slot_r.part, interspersed_parity);
      out_valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      load_mode_q <= ffo_pkg::FFO_LOAD_SERIAL;
      empty_thr_q <= `FFO_EMPTY_THR_RST;
      full_thr_q  <= `FFO_FULL_THR_RST;
      refused_q   <= 1'b0;
      data_out_q  <= `FFO_DATA_RST;
      out_valid_q <= 1'b0;
    end else begin
      load_mode_q <= load_mode_d;
      empty_thr_q <= empty_thr_d;
      full_thr_q  <= full_thr_d;
      refused_q   <= refused_d;
      data_out_q  <= data_out_d;
      out_valid_q <= out_valid_d;
    end
  end

  assign data_out         = data_out_q;
  assign data_out_valid   = out_valid_q;
  assign empty_threshold  = empty_thr_q;
  assign full_threshold   = full_thr_q;
  assign parallel_load_en = (load_mode_q == ffo_pkg::FFO_LOAD_PARALLEL);
  assign write_step       = write_ptr;
  assign read_step        = read_ptr;
  assign write_seq_done   = write_wrap;
  assign read_seq_done    = read_wrap;
  assign write_refused    = refused_q;

endmodule

// ==== tb/ffo_flag_offset_assertions.sv ====
`timescale 1ns/1ps
`include "ffo_consts.svh"
module ffo_chk #(
  parameter int COUNT_W = `FFO_COUNT_W
) (
  input wire logic                        clk_sys,
  input wire logic                        nrst,
  input wire logic                        master_clear_n,
  input wire logic                        load_select_n,
  input wire logic                        write_en_n,
  input wire logic                        read_en_n,
  input wire logic                        input_width_sel,
  input wire logic                        output_width_sel,
  input wire logic [`FFO_DEPTH_SEL_W-1:0] depth_sel,
  input wire logic                        fall_through_timing,
  input wire logic [COUNT_W-1:0]          mem_count,
  input wire logic                        out_reg_valid,
  input wire logic                        data_out_valid,
  input wire logic [`FFO_THR_W-1:0]       empty_threshold,
  input wire logic [`FFO_THR_W-1:0]       full_threshold,
  input wire logic                        parallel_load_en,
  input wire logic [`FFO_PTR_W-1:0]       write_step,
  input wire logic [`FFO_PTR_W-1:0]       read_step,
  input wire logic                        write_seq_done,
  input wire logic                        read_seq_done,
  input wire logic                        write_refused,
  input wire logic [COUNT_W-1:0]          flag_count
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence wr_take;
    master_clear_n && !load_select_n && !write_en_n;
  endsequence
  sequence rd_take;
    master_clear_n && !load_select_n && !read_en_n;
  endsequence
  sequence deep_nine;
    depth_sel == 2'h3 && !output_width_sel;
  endsequence
  write_adv_a: assert property (wr_take ##0 parallel_load_en
    |=> write_step != $past(write_step)) else $error("write step stuck");
  write_refuse_a: assert property (wr_take ##0 !parallel_load_en
    |=> write_refused && $stable(write_step) && $stable(empty_threshold))
    else $error("serial mode write not refused");
  read_pulse_a: assert property (rd_take |=> data_out_valid)
    else $error("readback missing");
  read_quiet_a: assert property (!master_clear_n || read_en_n
    || load_select_n |=> !data_out_valid) else $error("stray readback");
  clear_mode_a: assert property (!master_clear_n
    |=> parallel_load_en == !$past(load_select_n) && empty_threshold == 0
    && full_threshold == 0) else $error("master clear wrong");
  six_cycle_a: assert property (wr_take ##0 deep_nine
    ##0 (parallel_load_en && !input_width_sel && write_step == 3'h5)
    |=> write_seq_done && write_step == 0) else $error("six cycle wrap");
  four_write_a: assert property (wr_take ##0 (parallel_load_en
    && !input_width_sel && output_width_sel && depth_sel == 2'h3
    && write_step == 3'h3) |=> write_seq_done && write_step == 0)
    else $error("four write wrap");
  four_read_a: assert property (rd_take ##0 deep_nine
    ##0 (input_width_sel && read_step == 3'h3)
    |=> read_seq_done && read_step == 0) else $error("four read wrap");
  wide_pair_a: assert property (wr_take ##0 (parallel_load_en
    && input_width_sel && write_step == 3'h1)
    |=> write_seq_done && write_step == 0) else $error("wide pair wrap");
  occupancy_a: assert property (master_clear_n |=> flag_count
    == $past(mem_count) + COUNT_W'($past(fall_through_timing)
    & $past(out_reg_valid))) else $error("flag count wrong");
endmodule
bind ffo_flag_offset ffo_chk #(.COUNT_W(COUNT_W)) ffo_chk_inst (
  .clk_sys(clk_sys), .nrst(nrst), .master_clear_n(master_clear_n),
  .load_select_n(load_select_n), .write_en_n(write_en_n),
  .read_en_n(read_en_n), .input_width_sel(input_width_sel),
  .output_width_sel(output_width_sel), .depth_sel(depth_sel),
  .fall_through_timing(fall_through_timing), .mem_count(mem_count),
  .out_reg_valid(out_reg_valid), .data_out_valid(data_out_valid),
  .empty_threshold(empty_threshold), .full_threshold(full_threshold),
  .parallel_load_en(parallel_load_en), .write_step(write_step),
  .read_step(read_step), .write_seq_done(write_seq_done),
  .read_seq_done(read_seq_done), .write_refused(write_refused),
  .flag_count(flag_count));

// ==== tb/ffo_host_model.sv ====
`timescale 1ns/1ps
`include "ffo_consts.svh"
module ffo_host_model (
  input  wire logic                   clk_sys,
  input  wire logic [`FFO_DATA_W-1:0] data_out,
  input  wire logic                   data_out_valid,
  output logic                        load_select_n,
  output logic                        write_en_n,
  output logic                        read_en_n,
  output logic      [`FFO_DATA_W-1:0] data_in
);
  logic [`FFO_DATA_W-1:0] last_d;
  initial begin
    load_select_n = 1'b1;
    write_en_n = 1'b1;
    read_en_n = 1'b1;
    last_d = 18'h0_0000;
    data_in = 18'h0_0000;
  end
  task automatic set_ld(input logic v);
    load_select_n = v;
  endtask
  task automatic wr(input logic [`FFO_DATA_W-1:0] d);
    load_select_n = 1'b0;
    write_en_n = 1'b0;
    data_in = d;
    last_d = d;
    @(negedge clk_sys);
  endtask
  task automatic rd(output logic [`FFO_DATA_W-1:0] q, output logic v);
    load_select_n = 1'b0;
    read_en_n = 1'b0;
    @(negedge clk_sys);
    q = data_out;
    v = data_out_valid;
  endtask
  // Released lanes flip so stale data cannot match
  task automatic idle();
    load_select_n = 1'b1;
    write_en_n = 1'b1;
    read_en_n = 1'b1;
    data_in = ~last_d;
    @(negedge clk_sys);
  endtask
endmodule

// ==== tb/ffo_flag_offset_test.sv ====
`timescale 1ns/1ps
`include "ffo_consts.svh"
module ffo_flag_offset_test;
  logic        clk_sys, nrst, master_clear_n, load_select_n;
  logic        write_en_n, read_en_n, input_width_sel, output_width_sel;
  logic        interspersed_parity, fall_through_timing, out_reg_valid;
  logic        data_out_valid, parallel_load_en, write_seq_done;
  logic        read_seq_done, write_refused;
  logic [1:0]  depth_sel;
  logic [17:0] data_in, data_out, mem_count, flag_count;
  logic [16:0] empty_threshold, full_threshold;
  logic [2:0]  write_step, read_step;
  int          err_count, check_count;
  ffo_flag_offset #(.COUNT_W(18)) ffo_flag_offset_inst (
    .clk_sys(clk_sys), .nrst(nrst), .master_clear_n(master_clear_n),
    .load_select_n(load_select_n), .write_en_n(write_en_n),
    .read_en_n(read_en_n), .input_width_sel(input_width_sel),
    .output_width_sel(output_width_sel),
    .interspersed_parity(interspersed_parity), .depth_sel(depth_sel),
    .fall_through_timing(fall_through_timing), .data_in(data_in),
    .mem_count(mem_count), .out_reg_valid(out_reg_valid),
    .data_out(data_out), .data_out_valid(data_out_valid),
    .empty_threshold(empty_threshold), .full_threshold(full_threshold),
    .parallel_load_en(parallel_load_en), .write_step(write_step),
    .read_step(read_step), .write_seq_done(write_seq_done),
    .read_seq_done(read_seq_done), .write_refused(write_refused),
    .flag_count(flag_count));
  ffo_host_model ffo_host_model_inst (.clk_sys(clk_sys),
    .data_out(data_out), .data_out_valid(data_out_valid),
    .load_select_n(load_select_n), .write_en_n(write_en_n),
    .read_en_n(read_en_n), .data_in(data_in));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic clear_to(input logic ld, iw, ow, par, input logic [1:0] d);
    ffo_host_model_inst.set_ld(ld);
    master_clear_n = 1'b0;
    input_width_sel = iw;
    output_width_sel = ow;
    interspersed_parity = par;
    depth_sel = d;
    @(negedge clk_sys);
    master_clear_n = 1'b1;
    ffo_host_model_inst.set_ld(1'b1);
    @(negedge clk_sys);
    chk(parallel_load_en, !ld);
    chk(empty_threshold | full_threshold, 18'h0_0000);
  endtask
  // Upper lanes carry ones: they must be ignored
  task automatic put9(input logic [16:0] v, input logic deep);
    ffo_host_model_inst.wr({10'h3ff, v[7:0]});
    ffo_host_model_inst.wr({10'h3ff, v[15:8]});
    if (deep)
      ffo_host_model_inst.wr({17'h1_ffff, v[16]});
  endtask
  task automatic get9(input logic [16:0] m, input logic deep);
    logic [17:0] q;
    logic        v;
    ffo_host_model_inst.rd(q, v);
    chk(q, {10'h0, m[7:0]});
    ffo_host_model_inst.rd(q, v);
    chk(q, {10'h0, m[15:8]});
    if (deep) begin
      ffo_host_model_inst.rd(q, v);
      chk(q, {17'h0, m[16]});
    end
  endtask
  task automatic t_serial();
    logic [17:0] q;
    logic        v;
    clear_to(1'b1, 1'b1, 1'b1, 1'b0, 2'h0);
    ffo_host_model_inst.wr(18'h0_1234);
    chk(write_refused, 1'b1);
    ffo_host_model_inst.idle();
    chk(empty_threshold, 18'h0_0000);
    ffo_host_model_inst.rd(q, v);
    chk(v, 1'b1);
    ffo_host_model_inst.idle();
  endtask
  task automatic t_x18();
    logic [17:0] q;
    logic        v;
    clear_to(1'b0, 1'b1, 1'b1, 1'b0, 2'h0);
    ffo_host_model_inst.wr(18'h3_ffff);
    ffo_host_model_inst.wr(18'h3_0a5c);
    ffo_host_model_inst.idle();
    chk(empty_threshold, 18'h0_1fff);
    chk(full_threshold, 18'h0_0a5c);
    clear_to(1'b0, 1'b1, 1'b1, 1'b1, 2'h3);
    ffo_host_model_inst.wr({1'b1, 8'hbe, 1'b1, 8'hef});
    ffo_host_model_inst.wr({1'b1, 8'h12, 1'b1, 8'h34});
    ffo_host_model_inst.idle();
    chk(empty_threshold, 18'h0_beef);
    ffo_host_model_inst.rd(q, v);
    chk(q, {1'b0, 8'hbe, 1'b0, 8'hef});
    ffo_host_model_inst.rd(q, v);
    chk(q, {1'b0, 8'h12, 1'b0, 8'h34});
    ffo_host_model_inst.idle();
  endtask
  task automatic t_x9_deep();
    clear_to(1'b0, 1'b0, 1'b0, 1'b0, 2'h3);
    put9(17'h1_a5c3, 1'b1);
    chk(write_step, 3'h3);
    put9(17'h0_7e81, 1'b1);
    ffo_host_model_inst.idle();
    chk(empty_threshold, 18'h1_a5c3);
    chk(full_threshold, 18'h0_7e81);
    get9(17'h1_a5c3, 1'b1);
    get9(17'h0_7e81, 1'b1);
    ffo_host_model_inst.idle();
  endtask
  task automatic t_x9_shallow();
    clear_to(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    put9(17'h1_ffff, 1'b0);
    put9(17'h0_2345, 1'b0);
    ffo_host_model_inst.idle();
    chk(empty_threshold, 18'h0_3fff);
    chk(full_threshold, 18'h0_2345);
    get9(17'h0_3fff, 1'b0);
    get9(17'h0_2345, 1'b0);
    ffo_host_model_inst.idle();
  endtask
  task automatic t_mixed();
    logic [17:0] q;
    logic        v;
    clear_to(1'b0, 1'b0, 1'b1, 1'b0, 2'h3);
    put9(17'h1_c3a5, 1'b0);
    put9(17'h0_1111, 1'b0);
    ffo_host_model_inst.idle();
    chk(write_step, 3'h0);
    ffo_host_model_inst.rd(q, v);
    chk(q, 18'h0_c3a5);
    ffo_host_model_inst.idle();
    clear_to(1'b0, 1'b1, 1'b0, 1'b0, 2'h3);
    ffo_host_model_inst.wr(18'h3_5a0f);
    ffo_host_model_inst.wr(18'h3_0f5a);
    ffo_host_model_inst.idle();
    get9(17'h0_5a0f, 1'b0);
    get9(17'h0_0f5a, 1'b0);
    ffo_host_model_inst.idle();
    chk(read_step, 3'h0);
  endtask
  // Mid-run reset falls back to serial loading
  task automatic t_reset();
    nrst = 1'b0;
    @(negedge clk_sys);
    chk(parallel_load_en, 1'b0);
    chk(empty_threshold | full_threshold, 18'h0_0000);
    chk(data_out, 18'h0_0000);
    nrst = 1'b1;
    @(negedge clk_sys);
    ffo_host_model_inst.wr(18'h0_00ff);
    chk(write_refused, 1'b1);
    ffo_host_model_inst.idle();
    chk(empty_threshold, 18'h0_0000);
  endtask
  task automatic t_occ();
    mem_count = 18'h0_0041;
    out_reg_valid = 1'b1;
    fall_through_timing = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(flag_count, 18'h0_0042);
    fall_through_timing = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(flag_count, 18'h0_0041);
    out_reg_valid = 1'b0;
    mem_count = 18'h2_0001;
    fall_through_timing = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(flag_count, 18'h2_0001);
    master_clear_n = 1'b0;
    @(negedge clk_sys);
    chk(flag_count, 18'h0_0000);
    master_clear_n = 1'b1;
    @(negedge clk_sys);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
  initial begin
    err_count = 0;
    check_count = 0;
    nrst = 1'b0;
    master_clear_n = 1'b1;
    input_width_sel = 1'b0;
    output_width_sel = 1'b0;
    interspersed_parity = 1'b0;
    depth_sel = 2'h0;
    fall_through_timing = 1'b0;
    mem_count = 18'h0_0000;
    out_reg_valid = 1'b0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    @(negedge clk_sys);
    t_serial();
    t_x18();
    t_x9_deep();
    t_x9_shallow();
    t_mixed();
    t_reset();
    t_occ();
    report_and_stop();
  end
endmodule
